// ### spc_far_model.sv
// Purpose: host UART and remote station pin model
// Assumes: bench requests change just after a clock edge
// Notes: request-to-send held high until the device is ready
`timescale 1ns/100ps
`default_nettype none
module spc_far_model (
  // clock and device state
  input wire logic clk_in,
  input wire logic ready_in,
  // requested pin levels
  input wire logic rts_req_n_in,
  input wire logic cd_req_n_in,
  // pins
  output logic rts_n_out,
  output logic cd_n_out
);
  // host offers nothing before start-up ends
  always @(posedge clk_in)
  begin
    rts_n_out <= ready_in ? rts_req_n_in : 1'b1;
    cd_n_out <= cd_req_n_in;
  end
endmodule // spc_far_model
`default_nettype wire

// ### spc_pkg.sv
// Purpose: shared constants for the start-up and host control pin block
// Assumes: one 10 MHz core clock, synchronous active-high reset
// Notes: delay lengths are plain defaults; no figure is given for them
`default_nettype none
package spc_pkg;

  // ----------------------------------------------------------------
  // clocking
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10000000;
  localparam int DEV_CLK_HZ = 7372800;
  localparam int BAUD = 9600;
  localparam int BITCLK_PER_BIT = 16;
  // baud tick spacing in core clocks, rounded down, never below one
  localparam int BAUD_CYC_RAW = CLK_HZ / BAUD;
  localparam int BAUD_CYC = (BAUD_CYC_RAW < 1) ? 1 : BAUD_CYC_RAW;
  localparam int BAUD_W = 11;
  localparam logic [BAUD_W-1:0] BAUD_LAST = BAUD_W'(BAUD_CYC - 1);
  localparam logic [BAUD_W-1:0] BAUD_ZERO = 11'h000;

  // ----------------------------------------------------------------
  // start-up delays
  // ----------------------------------------------------------------
  localparam int PWRUP_US = 72000;
  localparam int SETTLE_CYC_OSC = 1024;
  localparam int PWRUP_CYC = (PWRUP_US * (CLK_HZ / 1000000));
  localparam int SETTLE_NS = (SETTLE_CYC_OSC * 1000) / 7;
  localparam int SETTLE_CYC_RAW = (SETTLE_NS + 99) / 100;
  localparam int SETTLE_CYC = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
  localparam int RST_SEQ_CYC = 16;
  localparam int CNT_W = 20;
  localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;
  localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;

  // ----------------------------------------------------------------
  // sequencer states, gray along power-up path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SPC_ST_PWRUP = 3'h0,
    SPC_ST_SETTLE = 3'h1,
    SPC_ST_HOLD = 3'h3,
    SPC_ST_RSTSEQ = 3'h2,
    SPC_ST_RUN = 3'h6
  } spc_state_type;

endpackage
`default_nettype wire

// ### spc_startup.sv
// How it works
// - reset pin low holds the block in reset.
// - after reset pin rises, a reset sequence runs before operation starts.
// - each power-up waits power-up delay, then oscillator settle delay, in order.
// - host and link run one fixed 9600 baud rate, no selection.
// - host request-to-send low allows sending to host; high stops it.
// - request-to-send stays local, never tied to remote flow-control bits.
// - carrier-detect pin is sampled and sent as link carrier bit.
// - local terminal-ready pin state is made locally, not from remote bit.
//
// Purpose: start-up sequencing and local host handshake pins
// Assumes: inputs synchronous-ish levels; rst_in high at power-up and at a restart
// Notes: ready_out gates host sending, the baud tick and link ready; the link carrier bit is not gated
`timescale 1ns/100ps
`default_nettype none
module spc_startup #(
  parameter int PWRUP_CYCLES = spc_pkg::PWRUP_CYC
) (
  // clock and resets
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic reset_pin_n_in,
  // host handshake pins
  input wire logic host_rts_n_in,
  input wire logic carrier_det_n_in,
  // device side status
  input wire logic host_tx_pending_in,
  input wire logic link_up_in,
  // outputs
  output logic ready_out,
  output logic baud_tick_out,
  output logic host_send_ok_out,
  output logic link_carrier_bit_out,
  output logic link_ready_n_out
);

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  logic [2:0] sync_q;
  logic pin_rst_n;
  logic rts_n;
  logic cd_n;

  // reset pin syncs to 0 so the block starts held
  spc_sync #(.W(3), .INIT(3'h6)) u_sync (
    .clk_in(core_clk_in),
    .rst_in(rst_in),
    .d_in({host_rts_n_in, carrier_det_n_in, reset_pin_n_in}),
    .q_out(sync_q)
  );
  assign rts_n = sync_q[2];
  assign cd_n = sync_q[1];
  assign pin_rst_n = sync_q[0];

  // ----------------------------------------------------------------
  // start-up sequencer
  // ----------------------------------------------------------------
  localparam logic [spc_pkg::CNT_W-1:0] PWRUP_LAST =
    spc_pkg::CNT_W'(PWRUP_CYCLES - 1);
  localparam logic [spc_pkg::CNT_W-1:0] SETTLE_LAST =
    spc_pkg::CNT_W'(spc_pkg::SETTLE_CYC - 1);
  localparam logic [spc_pkg::CNT_W-1:0] RSTSEQ_LAST =
    spc_pkg::CNT_W'(spc_pkg::RST_SEQ_CYC - 1);

  spc_pkg::spc_state_type st_r;
  spc_pkg::spc_state_type st_nxt;
  logic [spc_pkg::CNT_W-1:0] cnt_r;
  logic [spc_pkg::CNT_W-1:0] cnt_nxt;
  logic ready_r;
  logic ready_nxt;

  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r + spc_pkg::CNT_ONE;
    case (st_r)
      spc_pkg::SPC_ST_PWRUP:
      begin
        if (cnt_r == PWRUP_LAST)
        begin
          st_nxt = spc_pkg::SPC_ST_SETTLE;
          cnt_nxt = spc_pkg::CNT_ZERO;
        end
      end
      spc_pkg::SPC_ST_SETTLE:
      begin
        if (cnt_r == SETTLE_LAST)
        begin
          st_nxt = spc_pkg::SPC_ST_HOLD;
          cnt_nxt = spc_pkg::CNT_ZERO;
        end
      end
      spc_pkg::SPC_ST_HOLD:
      begin
        cnt_nxt = spc_pkg::CNT_ZERO;
        if (pin_rst_n)
          st_nxt = spc_pkg::SPC_ST_RSTSEQ;
      end
      spc_pkg::SPC_ST_RSTSEQ:
      begin
        if (cnt_r == RSTSEQ_LAST)
        begin
          st_nxt = spc_pkg::SPC_ST_RUN;
          cnt_nxt = spc_pkg::CNT_ZERO;
        end
      end
      spc_pkg::SPC_ST_RUN:
        cnt_nxt = spc_pkg::CNT_ZERO;
      default:
      begin
        st_nxt = spc_pkg::SPC_ST_PWRUP;
        cnt_nxt = spc_pkg::CNT_ZERO;
      end
    endcase
    // the pin forces reset at any time once delays are done
    if (!pin_rst_n && st_r != spc_pkg::SPC_ST_PWRUP &&
        st_r != spc_pkg::SPC_ST_SETTLE)
    begin
      st_nxt = spc_pkg::SPC_ST_HOLD;
      cnt_nxt = spc_pkg::CNT_ZERO;
    end
    ready_nxt = (st_nxt == spc_pkg::SPC_ST_RUN);
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      st_r <= spc_pkg::SPC_ST_PWRUP;
      cnt_r <= spc_pkg::CNT_ZERO;
      ready_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      ready_r <= ready_nxt;
    end
  end

  // ----------------------------------------------------------------
  // fixed baud tick, no rate select
  // ----------------------------------------------------------------
  // runs only in operation so the first bit is a full period
  logic [spc_pkg::BAUD_W-1:0] baud_r;
  logic [spc_pkg::BAUD_W-1:0] baud_nxt;
  logic tick_r;
  logic tick_nxt;

  always_comb
  begin
    baud_nxt = spc_pkg::BAUD_ZERO;
    tick_nxt = 1'b0;
    if (ready_r)
    begin
      if (baud_r == spc_pkg::BAUD_LAST)
        tick_nxt = 1'b1;
      else
        baud_nxt = baud_r + spc_pkg::BAUD_W'(1);
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      baud_r <= spc_pkg::BAUD_ZERO;
      tick_r <= 1'b0;
    end
    else
    begin
      baud_r <= baud_nxt;
      tick_r <= tick_nxt;
    end
  end

  // ----------------------------------------------------------------
  // local handshake pins
  // ----------------------------------------------------------------
  logic send_ok_r;
  logic send_ok_nxt;
  logic carrier_r;
  logic carrier_nxt;
  logic dsr_n_r;
  logic dsr_n_nxt;

  always_comb
  begin
    // uses only the local pin, never a remote flow bit
    send_ok_nxt = ready_r && !rts_n && host_tx_pending_in;
    carrier_nxt = cd_n;
    // made from local link state, not the remote terminal-ready bit
    dsr_n_nxt = !(ready_r && link_up_in);
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      send_ok_r <= 1'b0;
      carrier_r <= 1'b1;
      dsr_n_r <= 1'b1;
    end
    else
    begin
      send_ok_r <= send_ok_nxt;
      carrier_r <= carrier_nxt;
      dsr_n_r <= dsr_n_nxt;
    end
  end

  assign ready_out = ready_r;
  assign baud_tick_out = tick_r;
  assign host_send_ok_out = send_ok_r;
  assign link_carrier_bit_out = carrier_r;
  assign link_ready_n_out = dsr_n_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  hold_in_reset_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (!pin_rst_n && st_r == spc_pkg::SPC_ST_RUN) |=> !ready_r)
    else $error("ready stayed high while reset pin low");

  seq_before_run_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (st_r == spc_pkg::SPC_ST_HOLD ##1 st_r == spc_pkg::SPC_ST_RSTSEQ)
    |-> !ready_r [*8])
    else $error("operation began before reset sequence ended");

  delay_order_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (st_r == spc_pkg::SPC_ST_SETTLE) |->
    ($past(st_r) == spc_pkg::SPC_ST_PWRUP ||
    $past(st_r) == spc_pkg::SPC_ST_SETTLE))
    else $error("settle delay entered out of order");

  no_early_ready_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    ready_r |-> $past(st_r) == spc_pkg::SPC_ST_RSTSEQ ||
    $past(st_r) == spc_pkg::SPC_ST_RUN)
    else $error("ready without finished start-up");

  baud_period_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in || !ready_r)
    tick_r |=> !tick_r [*8])
    else $error("baud ticks too close");

  send_gate_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    $past(rts_n) |-> !send_ok_r)
    else $error("sent to host while request-to-send high");

  carrier_follow_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    ##1 carrier_r == $past(cd_n))
    else $error("carrier bit does not follow pin");

  link_pin_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    !ready_r |=> dsr_n_r)
    else $error("link ready asserted while not operating");

endmodule // spc_startup
`default_nettype wire

// ### spc_sync.sv
// Purpose: two-flop synchroniser for a group of input levels
// Assumes: inputs are levels, not pulses
// Notes: first stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none
module spc_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // levels
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  always_comb
  begin
    meta_nxt = d_in;
    q_nxt = meta_r;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      meta_r <= INIT;
      q_r <= INIT;
    end
    else
    begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q_out = q_r;

endmodule // spc_sync
`default_nettype wire

// ### tb_top.sv
// Purpose: self-checking bench for the start-up and handshake pins
// Assumes: power-up delay shortened to 10 cycles
// Notes: results are noted in a queue and checked by a monitor
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic pin_n = 1'b1;
  logic rts_req_n = 1'b1;
  logic cd_req_n = 1'b1;
  logic pending = 1'b0;
  logic link_up = 1'b0;
  logic rts_n, cd_n, ready, tick, send_ok, carrier, link_rdy_n;
  logic r, c, p, l;
  int errors = 0;
  int samples_checked = 0;
  int n;
  logic [3:0] notes[$];
  event probe;
  localparam int START_MIN = 10 + spc_pkg::SETTLE_CYC + spc_pkg::RST_SEQ_CYC;

  always #50 core_clk_in = ~core_clk_in;

  spc_far_model i_spc_far_model (.clk_in(core_clk_in), .ready_in(ready),
    .rts_req_n_in(rts_req_n), .cd_req_n_in(cd_req_n),
    .rts_n_out(rts_n), .cd_n_out(cd_n));

  spc_startup #(.PWRUP_CYCLES(10)) i_spc_startup (.core_clk_in(core_clk_in),
    .rst_in(rst_in), .reset_pin_n_in(pin_n), .host_rts_n_in(rts_n),
    .carrier_det_n_in(cd_n), .host_tx_pending_in(pending),
    .link_up_in(link_up), .ready_out(ready), .baud_tick_out(tick),
    .host_send_ok_out(send_ok), .link_carrier_bit_out(carrier),
    .link_ready_n_out(link_rdy_n));

  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic note(input logic [3:0] exp);
    @(negedge core_clk_in);
    notes.push_back(exp);
    -> probe;
  endtask

  always @(probe)
  begin
    check({28'h0000000, ready, send_ok, carrier, link_rdy_n},
      {28'h0000000, notes.pop_front()});
  end

  // bounded wait; sampled on the falling edge so updates have landed
  task automatic wait_for(ref logic sig, output int cyc);
    cyc = 0;
    do
    begin
      @(negedge core_clk_in);
      cyc++;
    end
    while (sig !== 1'b1 && cyc < 3000);
    // a wait that runs out is a failure, not a long pass
    if (sig !== 1'b1)
      errors++;
  endtask

  task automatic give_verdict;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (12000) @(posedge core_clk_in);
    errors++;
    give_verdict;
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h1DA276AD));
    repeat (5) @(posedge core_clk_in);
    rst_in <= 1'b0;
    wait_for(ready, n);
    check(n >= START_MIN, 1'b1);
    $display("test startup done");
    wait_for(tick, n);
    wait_for(tick, n);
    check(n, spc_pkg::BAUD_CYC);
    $display("test baud done");
    repeat (24)
    begin
      r = 1'($urandom_range(1, 0));
      c = 1'($urandom_range(1, 0));
      p = 1'($urandom_range(1, 0));
      l = 1'($urandom_range(1, 0));
      @(posedge core_clk_in);
      rts_req_n <= r;
      cd_req_n <= c;
      pending <= p;
      link_up <= l;
      repeat (5) @(posedge core_clk_in);
      note({1'b1, p & ~r, c, ~l});
    end
    $display("test handshake done");
    @(posedge core_clk_in);
    cd_req_n <= 1'b1;
    link_up <= 1'b0;
    pending <= 1'b1;
    rts_req_n <= 1'b0;
    pin_n <= 1'b0;
    repeat (40) @(posedge core_clk_in);
    note(4'h3);
    @(posedge core_clk_in);
    pin_n <= 1'b1;
    wait_for(ready, n);
    check(n >= spc_pkg::RST_SEQ_CYC, 1'b1);
    $display("test reset pin done");
    @(posedge core_clk_in);
    rst_in <= 1'b1;
    @(posedge core_clk_in);
    rst_in <= 1'b0;
    note(4'h3);
    wait_for(ready, n);
    check(n >= START_MIN - 1, 1'b1);
    $display("test restart done");
    give_verdict;
  end
endmodule // tb_top
`default_nettype wire
